// >>> logic/smp_consts.svh
// constants for the switch-mode pwm time base: register offsets, field positions, codes
// assumes byte addressing on a 32-bit register bus, one register per aligned word
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH
`define SMP_OFF_MAIN_CTRL 8'h00
`define SMP_OFF_CLK_CTRL 8'h04
`define SMP_OFF_PERIOD 8'h08
`define SMP_OFF_RISE 8'h0C
`define SMP_OFF_FALL 8'h10
`define SMP_OFF_COUNTER 8'h14
`define SMP_OFF_TB_IRQ 8'h18
`define SMP_OFF_SYS_IRQ 8'h1C
`define SMP_OFF_BLANK_CTRL 8'h20
`define SMP_OFF_RBLANK_TIME 8'h24
`define SMP_OFF_FBLANK_TIME 8'h28
`define SMP_OFF_RBLANK_SRC 8'h2C
`define SMP_OFF_FBLANK_SRC 8'h30
`define SMP_OFF_EVENT_SRC 8'h34
`define SMP_OFF_OUT_EN 8'h38
`define SMP_OFF_STEER 8'h3C
`define SMP_OFF_POLARITY 8'h40
`define SMP_CTRL_EN_BIT 0
`define SMP_CTRL_LD_BIT 1
`define SMP_CTRL_MODE_LSB 4
`define SMP_CLK_DIV_LSB 4
`define SMP_IRQ_EN_LSB 4
`define SMP_FBLANK_MODE_LSB 4
`define SMP_EVSRC_RISE_LSB 8
`define SMP_EVSRC_FALL_LSB 16
`define SMP_EVSRC_SHUT_LSB 24
`define SMP_MODE_SINGLE 4'h0
`define SMP_MODE_COMPL 4'h1
`define SMP_MODE_SIX_STEP 4'h2
`define SMP_CSRC_SYS 2'h0
`define SMP_CSRC_FAST 2'h1
`define SMP_CSRC_EXT 2'h2
`define SMP_BLANK_IMMED 2'h1
`define SMP_TB_MAX 16'hFFFF
`define SMP_RST_WORD 32'h0000_0000
`endif

// >>> logic/smp_pkg.sv
// types shared by the switch-mode pwm time base
// no assumptions beyond a SystemVerilog compiler
package smp_pkg;
  // asynchronous event sources, one bit each
  typedef struct packed {
    logic c3;
    logic c2;
    logic c1;
    logic pin;
  } smp_src_t;
  // time-base interrupt sources
  typedef struct packed {
    logic period;
    logic fall;
    logic rise;
    logic ovf;
  } smp_tb_flags_t;
  // one blanking window
  typedef struct packed {
    logic active;
    logic [7:0] cnt;
  } smp_blank_t;
  // event source choice: time base match plus asynchronous inputs
  typedef struct packed {
    logic tb;
    smp_src_t asy;
  } smp_evsel_t;
endpackage

// >>> logic/smp_pwm_timebase.sv
// single-phase pwm time base with blanking, interrupt flags and output control
// assumes an Avalon-MM master on the register port and inputs synchronous to clk
//
// Notes on behaviour
// - equal fall and rise values give 0% duty
// - fall beyond period never matches, 100% duty
// - four flags set on counter matches and wrap, enables independent
// - summary flag sets on an enabled source flag or a software write
// - flags sticky; disable clears them, not summary
// - software-set flag interrupts like a hardware event
// - two-bit field picks one of three clocks
// - fast oscillator kept running whenever it is selected
// - prescaler divides by 1, 2, 4, 8
// - comparators trigger on rising edge; shutdown level
// - external pin unsynchronised, rising edge triggers
// - blanking masks async inputs, time base untouched
// - separate blank modes; disabled passes inputs unchanged
// - event starts blank counter, ends at equal count
// - per-window source selects mask all event kinds
// - realised blank time within one tick
// - per-pin enable; disabled pin is not driven
// - enabled but unsteered pin held inactive level
// - steering acts only in steerable modes
// - per-pin polarity inverts active sense
// - rise sets steered pins active, fall inactive
// - 16-bit counter, period event resets it
// - wrap without period event sets overflow flag
// - first fall per period acts, first rise only before any fall
// - match values double-buffered, loaded on period event after a load request
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "smp_consts.svh"

module smp_pwm_timebase import smp_pkg::*; #(
  parameter logic [3:0] SINGLE_MODE = `SMP_MODE_SINGLE,
  parameter logic [3:0] COMPL_MODE = `SMP_MODE_COMPL,
  parameter logic [3:0] SIX_STEP_MODE = `SMP_MODE_SIX_STEP
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // clock sources
  input wire logic fast_osc_tick,
  input wire logic ext_clk_pin,
  output logic fast_osc_keep_on,
  // asynchronous event inputs
  input wire logic comparator1_event,
  input wire logic comparator2_event,
  input wire logic comparator3_event,
  input wire logic external_event_pin,
  // events to downstream stages
  output logic rise_event,
  output logic fall_event,
  output logic period_event,
  output logic shutdown_request,
  // pwm pins
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic pwm_out_e,
  output logic pwm_out_f,
  output logic [5:0] pwm_out_oe,
  // interrupt to cpu
  output logic cpu_irq
);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction

  // one step of a blanking window; the start is seen on clk but counting waits for a tick
  function automatic smp_blank_t blank_next(input smp_blank_t b, input logic start, input logic tk,
                                            input logic [1:0] mode, input logic [7:0] tim);
    smp_blank_t n;
    n = b;
    if (mode != `SMP_BLANK_IMMED) begin
      n = '0;
    end else if (start) begin
      n.active = 1'b1;
      n.cnt = 8'h00;
    end else if (b.active && tk) begin
      if (b.cnt == tim) begin
        n.active = 1'b0;
      end else begin
        n.cnt = b.cnt + 8'h01;
      end
    end
    return n;
  endfunction

  logic en_q;
  logic load_req_q;
  logic [3:0] mode_q;
  logic [1:0] clk_sel_q;
  logic [1:0] clk_div_q;
  logic [15:0] period_q;
  logic [15:0] rise_q;
  logic [15:0] fall_q;
  logic [15:0] period_buf_q;
  logic [15:0] rise_buf_q;
  logic [15:0] fall_buf_q;
  logic [15:0] counter_q;
  smp_tb_flags_t irq_en_q;
  smp_tb_flags_t irq_flag_q;
  logic sum_flag_q;
  logic sum_en_q;
  logic periph_gate_q;
  logic global_gate_q;
  logic [1:0] rblank_mode_q;
  logic [1:0] fblank_mode_q;
  logic [7:0] rblank_time_q;
  logic [7:0] fblank_time_q;
  smp_src_t rblank_src_q;
  smp_src_t fblank_src_q;
  smp_evsel_t per_sel_q;
  smp_evsel_t rise_sel_q;
  smp_evsel_t fall_sel_q;
  smp_src_t shut_sel_q;
  logic [5:0] oen_q;
  logic [5:0] steer_q;
  logic [5:0] pol_q;
  logic ext_prev_q;
  logic [2:0] div_cnt_q;
  smp_src_t src_prev_q;
  smp_blank_t rblank_q;
  smp_blank_t fblank_q;
  logic rise_done_q;
  logic fall_done_q;
  logic pwm_q;

  logic req;
  logic wr_go;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic src_tick;
  logic tick;
  smp_src_t src_now;
  smp_src_t src_edge;
  smp_src_t blank_mask;
  smp_src_t edge_ok;
  smp_src_t level_ok;
  logic per_match;
  logic rise_match;
  logic fall_match;
  logic per_ev;
  logic rise_ev;
  logic fall_ev;
  logic rise_act;
  logic fall_act;
  logic wrap;
  logic steerable;
  logic [5:0] pin_level;
  smp_tb_flags_t hw_flags;

  assign req = avs_read | avs_write;
  assign wr_go = avs_write & ~avs_waitrequest;

  // one wait state: the answer comes at the second edge of every request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_word = `SMP_RST_WORD;
    unique case (avs_address)
      `SMP_OFF_MAIN_CTRL: begin
        rd_word[`SMP_CTRL_EN_BIT] = en_q;
        rd_word[`SMP_CTRL_LD_BIT] = load_req_q;
        rd_word[`SMP_CTRL_MODE_LSB +: 4] = mode_q;
      end
      `SMP_OFF_CLK_CTRL: begin
        rd_word[1:0] = clk_sel_q;
        rd_word[`SMP_CLK_DIV_LSB +: 2] = clk_div_q;
      end
      `SMP_OFF_PERIOD: rd_word[15:0] = period_q;
      `SMP_OFF_RISE: rd_word[15:0] = rise_q;
      `SMP_OFF_FALL: rd_word[15:0] = fall_q;
      `SMP_OFF_COUNTER: rd_word[15:0] = counter_q;
      `SMP_OFF_TB_IRQ: begin
        rd_word[3:0] = irq_flag_q;
        rd_word[`SMP_IRQ_EN_LSB +: 4] = irq_en_q;
      end
      `SMP_OFF_SYS_IRQ: rd_word[3:0] = {global_gate_q, periph_gate_q, sum_en_q, sum_flag_q};
      `SMP_OFF_BLANK_CTRL: begin
        rd_word[1:0] = rblank_mode_q;
        rd_word[`SMP_FBLANK_MODE_LSB +: 2] = fblank_mode_q;
      end
      `SMP_OFF_RBLANK_TIME: rd_word[7:0] = rblank_time_q;
      `SMP_OFF_FBLANK_TIME: rd_word[7:0] = fblank_time_q;
      `SMP_OFF_RBLANK_SRC: rd_word[3:0] = rblank_src_q;
      `SMP_OFF_FBLANK_SRC: rd_word[3:0] = fblank_src_q;
      `SMP_OFF_EVENT_SRC: begin
        rd_word[4:0] = per_sel_q;
        rd_word[`SMP_EVSRC_RISE_LSB +: 5] = rise_sel_q;
        rd_word[`SMP_EVSRC_FALL_LSB +: 5] = fall_sel_q;
        rd_word[`SMP_EVSRC_SHUT_LSB +: 4] = shut_sel_q;
      end
      `SMP_OFF_OUT_EN: rd_word[5:0] = oen_q;
      `SMP_OFF_STEER: rd_word[5:0] = steer_q;
      `SMP_OFF_POLARITY: rd_word[5:0] = pol_q;
      default: rd_word = `SMP_RST_WORD;
    endcase
  end

  // read data is captured in the wait cycle and stands at the edge that ends the request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= `SMP_RST_WORD;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_word;
    end
  end

  assign wr_word = be_merge(rd_word, avs_writedata, avs_byteenable);

  // plain configuration registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      mode_q <= SINGLE_MODE;
      clk_sel_q <= `SMP_CSRC_SYS;
      clk_div_q <= 2'h0;
      period_q <= 16'h0000;
      rise_q <= 16'h0000;
      fall_q <= 16'h0000;
      irq_en_q <= '0;
      sum_en_q <= 1'b0;
      periph_gate_q <= 1'b0;
      global_gate_q <= 1'b0;
      rblank_mode_q <= 2'h0;
      fblank_mode_q <= 2'h0;
      rblank_time_q <= 8'h00;
      fblank_time_q <= 8'h00;
      rblank_src_q <= '0;
      fblank_src_q <= '0;
      per_sel_q <= '0;
      rise_sel_q <= '0;
      fall_sel_q <= '0;
      shut_sel_q <= '0;
      oen_q <= 6'h00;
      steer_q <= 6'h00;
      pol_q <= 6'h00;
    end else if (wr_go) begin
      unique case (avs_address)
        `SMP_OFF_MAIN_CTRL: begin
          en_q <= wr_word[`SMP_CTRL_EN_BIT];
          mode_q <= wr_word[`SMP_CTRL_MODE_LSB +: 4];
        end
        `SMP_OFF_CLK_CTRL: begin
          clk_sel_q <= wr_word[1:0];
          clk_div_q <= wr_word[`SMP_CLK_DIV_LSB +: 2];
        end
        `SMP_OFF_PERIOD: period_q <= wr_word[15:0];
        `SMP_OFF_RISE: rise_q <= wr_word[15:0];
        `SMP_OFF_FALL: fall_q <= wr_word[15:0];
        `SMP_OFF_TB_IRQ: irq_en_q <= wr_word[`SMP_IRQ_EN_LSB +: 4];
        `SMP_OFF_SYS_IRQ: begin
          sum_en_q <= wr_word[1];
          periph_gate_q <= wr_word[2];
          global_gate_q <= wr_word[3];
        end
        `SMP_OFF_BLANK_CTRL: begin
          rblank_mode_q <= wr_word[1:0];
          fblank_mode_q <= wr_word[`SMP_FBLANK_MODE_LSB +: 2];
        end
        `SMP_OFF_RBLANK_TIME: rblank_time_q <= wr_word[7:0];
        `SMP_OFF_FBLANK_TIME: fblank_time_q <= wr_word[7:0];
        `SMP_OFF_RBLANK_SRC: rblank_src_q <= wr_word[3:0];
        `SMP_OFF_FBLANK_SRC: fblank_src_q <= wr_word[3:0];
        `SMP_OFF_EVENT_SRC: begin
          per_sel_q <= wr_word[4:0];
          rise_sel_q <= wr_word[`SMP_EVSRC_RISE_LSB +: 5];
          fall_sel_q <= wr_word[`SMP_EVSRC_FALL_LSB +: 5];
          shut_sel_q <= wr_word[`SMP_EVSRC_SHUT_LSB +: 4];
        end
        `SMP_OFF_OUT_EN: oen_q <= wr_word[5:0];
        `SMP_OFF_STEER: steer_q <= wr_word[5:0];
        `SMP_OFF_POLARITY: pol_q <= wr_word[5:0];
        default: ;
      endcase
    end
  end

  // clock source and prescaler: the module tick is an enable pulse on clk
  always_comb begin
    unique case (clk_sel_q)
      `SMP_CSRC_FAST: src_tick = fast_osc_tick;
      `SMP_CSRC_EXT: src_tick = ext_clk_pin & ~ext_prev_q;
      default: src_tick = 1'b1;
    endcase
  end

  assign tick = en_q & src_tick & ((div_cnt_q & div_mask(clk_div_q)) == div_mask(clk_div_q));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_prev_q <= 1'b0;
      div_cnt_q <= 3'h0;
      fast_osc_keep_on <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk_pin;
      // independent of the module enable, so software must move off this source to save power
      fast_osc_keep_on <= (clk_sel_q == `SMP_CSRC_FAST);
      if (!en_q) begin
        div_cnt_q <= 3'h0;
      end else if (src_tick) begin
        div_cnt_q <= div_cnt_q + 3'h1;
      end
    end
  end

  // asynchronous inputs: no synchroniser on the pin, only the previous level for edge detection
  assign src_now = '{c3: comparator3_event, c2: comparator2_event, c1: comparator1_event,
                     pin: external_event_pin};
  assign src_edge = src_now & ~src_prev_q;
  assign blank_mask = (rblank_q.active ? rblank_src_q : 4'h0) | (fblank_q.active ? fblank_src_q : 4'h0);
  assign edge_ok = src_edge & ~blank_mask;
  assign level_ok = src_now & ~blank_mask;

  // time-base matches bypass the blanking mask
  assign per_match = tick & (counter_q == period_buf_q);
  assign rise_match = tick & (counter_q == rise_buf_q);
  assign fall_match = tick & (counter_q == fall_buf_q);
  assign per_ev = en_q & ((per_sel_q.tb & per_match) | |(edge_ok & per_sel_q.asy));
  assign rise_ev = en_q & ((rise_sel_q.tb & rise_match) | |(edge_ok & rise_sel_q.asy));
  assign fall_ev = en_q & ((fall_sel_q.tb & fall_match) | |(edge_ok & fall_sel_q.asy));
  assign rise_act = rise_ev & ~rise_done_q & ~fall_done_q;
  assign fall_act = fall_ev & ~fall_done_q;
  assign wrap = tick & ~per_ev & (counter_q == `SMP_TB_MAX);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_prev_q <= '0;
      rblank_q <= '0;
      fblank_q <= '0;
    end else begin
      src_prev_q <= src_now;
      rblank_q <= blank_next(rblank_q, rise_act, tick, rblank_mode_q, rblank_time_q);
      fblank_q <= blank_next(fblank_q, fall_act, tick, fblank_mode_q, fblank_time_q);
    end
  end

  // counter, match buffers and once-per-period bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      counter_q <= 16'h0000;
      period_buf_q <= 16'h0000;
      rise_buf_q <= 16'h0000;
      fall_buf_q <= 16'h0000;
      load_req_q <= 1'b0;
      rise_done_q <= 1'b0;
      fall_done_q <= 1'b0;
    end else begin
      if (!en_q) begin
        counter_q <= 16'h0000;
      end else if (per_ev) begin
        counter_q <= 16'h0000;
      end else if (tick) begin
        counter_q <= counter_q + 16'h0001;
      end
      // a software set in the same cycle as the load keeps the request pending
      if (wr_go && avs_address == `SMP_OFF_MAIN_CTRL && wr_word[`SMP_CTRL_LD_BIT]) begin
        load_req_q <= 1'b1;
      end else if (per_ev && load_req_q) begin
        load_req_q <= 1'b0;
      end
      if (per_ev && load_req_q) begin
        period_buf_q <= period_q;
        rise_buf_q <= rise_q;
        fall_buf_q <= fall_q;
      end
      if (!en_q || per_ev) begin
        rise_done_q <= 1'b0;
        fall_done_q <= 1'b0;
      end else begin
        rise_done_q <= rise_done_q | rise_act;
        fall_done_q <= fall_done_q | fall_act;
      end
    end
  end

  // interrupt flags: hardware set beats software clear in the same cycle
  assign hw_flags = '{period: per_match, fall: fall_match, rise: rise_match, ovf: wrap};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_flag_q <= '0;
      sum_flag_q <= 1'b0;
      cpu_irq <= 1'b0;
    end else begin
      if (!en_q) begin
        irq_flag_q <= '0;
      end else if (wr_go && avs_address == `SMP_OFF_TB_IRQ) begin
        irq_flag_q <= smp_tb_flags_t'(wr_word[3:0]) | hw_flags;
      end else begin
        irq_flag_q <= irq_flag_q | hw_flags;
      end
      // stays set while any enabled source flag is set, so source flags must be cleared first
      if (|(irq_flag_q & irq_en_q)) begin
        sum_flag_q <= 1'b1;
      end else if (wr_go && avs_address == `SMP_OFF_SYS_IRQ) begin
        sum_flag_q <= wr_word[0];
      end
      cpu_irq <= sum_flag_q & sum_en_q & periph_gate_q & global_gate_q;
    end
  end

  // waveform and pins
  assign steerable = (mode_q == SINGLE_MODE) | (mode_q == COMPL_MODE) | (mode_q == SIX_STEP_MODE);
  assign pin_level = ({6{pwm_q & steerable}} & steer_q) ^ pol_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwm_q <= 1'b0;
      rise_event <= 1'b0;
      fall_event <= 1'b0;
      period_event <= 1'b0;
      shutdown_request <= 1'b0;
      pwm_out_a <= 1'b0;
      pwm_out_b <= 1'b0;
      pwm_out_c <= 1'b0;
      pwm_out_d <= 1'b0;
      pwm_out_e <= 1'b0;
      pwm_out_f <= 1'b0;
      pwm_out_oe <= 6'h00;
    end else begin
      if (!en_q || fall_act) begin
        pwm_q <= 1'b0;
      end else if (rise_act) begin
        pwm_q <= 1'b1;
      end
      rise_event <= rise_act;
      fall_event <= fall_act;
      period_event <= per_ev;
      shutdown_request <= en_q & |(level_ok & shut_sel_q);
      pwm_out_a <= pin_level[0];
      pwm_out_b <= pin_level[1];
      pwm_out_c <= pin_level[2];
      pwm_out_d <= pin_level[3];
      pwm_out_e <= pin_level[4];
      pwm_out_f <= pin_level[5];
      pwm_out_oe <= oen_q;
    end
  end

endmodule

// >>> verif/smp_pwm_timebase_chk.sv
// port checker for the switch-mode pwm time base
// assumes one clock and a synchronous active-low reset; bound to the top module
`timescale 1ns/1ps
`include "smp_consts.svh"
module smp_pwm_timebase_chk import smp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // pins and events
  input wire logic fast_osc_keep_on,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic [5:0] pwm_out_oe
);
  logic wr_ok;
  logic [5:0] pol_q, steer_q, oen_q;
  logic [3:0] mode_q;
  logic fast_q;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // shadows of the low byte of the registers the pins depend on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pol_q <= 6'h00;
      steer_q <= 6'h00;
      oen_q <= 6'h00;
      mode_q <= 4'h0;
      fast_q <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address == `SMP_OFF_POLARITY) pol_q <= avs_writedata[5:0];
      if (avs_address == `SMP_OFF_STEER) steer_q <= avs_writedata[5:0];
      if (avs_address == `SMP_OFF_OUT_EN) oen_q <= avs_writedata[5:0];
      if (avs_address == `SMP_OFF_MAIN_CTRL) mode_q <= avs_writedata[7:4];
      if (avs_address == `SMP_OFF_CLK_CTRL) fast_q <= (avs_writedata[1:0] == `SMP_CSRC_FAST);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  one_wait_a: assert property (bus_req |=> bus_ans) else $error("bus answer late");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest) else $error("waitrequest low while idle");
  keep_on_a: assert property (
    wr_ok && avs_address == `SMP_OFF_CLK_CTRL |=> ##1 (fast_osc_keep_on == fast_q))
    else $error("keep-on differs from clock select");
  oe_copy_a: assert property (pwm_out_oe == $past(oen_q)) else $error("pin enables differ from register");
  pin_cause_a: assert property (
    $changed(pwm_out_a) |-> $past(rise_event) || $past(fall_event) || $past(wr_ok, 2) || $past(wr_ok, 3))
    else $error("pin a moved without event or write");
  fall_drive_a: assert property (fall_event && pwm_out_oe[0] |=> pwm_out_a == pol_q[0])
    else $error("pin a not inactive on fall");
  rise_drive_a: assert property (
    rise_event && !fall_event && pwm_out_oe[0] && steer_q[0] && mode_q == `SMP_MODE_SINGLE
    |=> pwm_out_a != pol_q[0]) else $error("pin a not active on rise");
  unsteer_a: assert property (
    pwm_out_oe[1] && !steer_q[1] && !$past(wr_ok) && !$past(wr_ok, 2) |-> pwm_out_b == pol_q[1])
    else $error("unsteered pin b active");
endmodule
bind smp_pwm_timebase smp_pwm_timebase_chk smp_pwm_timebase_chk_inst (.clk, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .fast_osc_keep_on, .rise_event, .fall_event,
  .pwm_out_a, .pwm_out_b, .pwm_out_oe);

// >>> verif/smp_stage_model.sv
// far side: comparator outputs, event pin and the two outside clock sources
// assumes a one-clk fire pulse from the bench launches a short high level
`timescale 1ns/1ps
module smp_stage_model import smp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench command
  input wire smp_src_t fire,
  // lines toward the block
  output smp_src_t lines,
  output logic fast_osc_tick,
  output logic ext_clk_pin
);
  logic [3:0] hold_q [4];
  logic [3:0] lvl;
  logic [1:0] div_q;
  // short pulses so a blanked edge has ended before the window closes
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b) hold_q[i] <= 4'h0;
      else if (fire[i]) hold_q[i] <= 4'h4;
      else if (hold_q[i] != 4'h0) hold_q[i] <= hold_q[i] - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) lvl[i] = (hold_q[i] != 4'h0);
  end
  assign lines = smp_src_t'(lvl);
  assign fast_osc_tick = div_q[0];
  assign ext_clk_pin = div_q[1];
endmodule

// >>> verif/tb_smp_pwm_timebase.sv
// self-checking bench: bus tasks and register-driven scenarios for the pwm time base
// assumes the stage model supplies comparator lines, event pin and clock sources
`timescale 1ns/1ps
`include "smp_consts.svh"
module tb_smp_pwm_timebase import smp_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata;
  logic avs_waitrequest, fast_osc_tick, ext_clk_pin, fast_osc_keep_on;
  logic rise_event, fall_event, period_event, shutdown_request, cpu_irq, pwm_out_a, pwm_out_b;
  logic [5:0] pwm_out_oe;
  smp_src_t fire = '0;
  smp_src_t lines;
  int fails = 0;
  int comparisons = 0;
  int hi_a, hi_b, n_re, n_pe, n_sd;
  logic [1:0] cs [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [1:0] dv [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  int pe_exp [6] = '{32, 16, 8, 4, 16, 8};
  always #5 clk = ~clk;
  smp_pwm_timebase smp_pwm_timebase_inst (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .fast_osc_tick, .ext_clk_pin, .fast_osc_keep_on,
    .comparator1_event(lines.c1), .comparator2_event(lines.c2), .comparator3_event(lines.c3),
    .external_event_pin(lines.pin), .rise_event, .fall_event, .period_event, .shutdown_request, .pwm_out_a,
    .pwm_out_b, .pwm_out_c(), .pwm_out_d(), .pwm_out_e(), .pwm_out_f(), .pwm_out_oe, .cpu_irq);
  smp_stage_model smp_stage_model_inst (.clk, .rst_b, .fire, .lines, .fast_osc_tick, .ext_clk_pin);
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle edge after release: no strobe is driven twice in one step
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      fails++;
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic wait_ev(input logic fall);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((fall ? fall_event : period_event) !== 1'b1 && n < 200);
    if (n >= 200) begin
      fails++;
      conclude();
    end
  endtask
  task automatic watch(input int n, input logic clr);
    if (clr) {hi_a, hi_b, n_re, n_pe, n_sd} = '0;
    repeat (n) begin
      @(posedge clk);
      hi_a += int'(pwm_out_a === 1'b1);
      hi_b += int'(pwm_out_b === 1'b1);
      n_re += int'(rise_event === 1'b1);
      n_pe += int'(period_event === 1'b1);
      n_sd += int'(shutdown_request === 1'b1);
    end
  endtask
  task automatic pulse(input smp_src_t s);
    fire <= s;
    @(posedge clk);
    fire <= '0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h80, 32'h0);
    bus(1'b0, `SMP_OFF_COUNTER, 32'h1234);
    rd(`SMP_OFF_COUNTER, 32'h0);
    bus(1'b0, `SMP_OFF_PERIOD, 32'h4);
    bus(1'b0, `SMP_OFF_RISE, 32'h1);
    bus(1'b0, `SMP_OFF_FALL, 32'h3);
    rd(`SMP_OFF_FALL, 32'h3);
    bus(1'b0, `SMP_OFF_EVENT_SRC, 32'h101010);
    bus(1'b0, `SMP_OFF_STEER, 32'h1);
    bus(1'b0, `SMP_OFF_OUT_EN, 32'h3);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h3);
    watch(40, 1'b1);
    watch(20, 1'b1);
    chk(hi_a, 8);
    chk(hi_b, 0);
    chk(n_pe, 4);
    rd(`SMP_OFF_TB_IRQ, 32'hE);
    rd(`SMP_OFF_SYS_IRQ, 32'h0);
    $display("test duty done");
    bus(1'b0, `SMP_OFF_FALL, 32'h9);
    watch(20, 1'b1);
    chk(hi_a, 8);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h3);
    watch(20, 1'b1);
    watch(20, 1'b1);
    chk(hi_a, 20);
    bus(1'b0, `SMP_OFF_FALL, 32'h1);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h3);
    watch(20, 1'b1);
    watch(20, 1'b1);
    chk(hi_a, 0);
    bus(1'b0, `SMP_OFF_FALL, 32'h3);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h3);
    bus(1'b0, `SMP_OFF_POLARITY, 32'h3);
    watch(20, 1'b1);
    watch(20, 1'b1);
    chk(hi_a, 12);
    chk(hi_b, 20);
    bus(1'b0, `SMP_OFF_POLARITY, 32'h0);
    $display("test limits done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, `SMP_OFF_CLK_CTRL, {26'h0, dv[i], 2'h0, cs[i]});
      watch(40, 1'b1);
      watch(160, 1'b1);
      chk({31'h0, n_pe >= pe_exp[i] - 1 && n_pe <= pe_exp[i] + 1}, 32'h1);
      chk({31'h0, fast_osc_keep_on}, {31'h0, cs[i] == `SMP_CSRC_FAST});
    end
    bus(1'b0, `SMP_OFF_CLK_CTRL, 32'h0);
    $display("test clocks done");
    bus(1'b0, `SMP_OFF_TB_IRQ, 32'h80);
    bus(1'b0, `SMP_OFF_SYS_IRQ, 32'hE);
    watch(10, 1'b1);
    rd(`SMP_OFF_SYS_IRQ, 32'hF);
    chk({31'h0, cpu_irq}, 32'h1);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h0);
    rd(`SMP_OFF_TB_IRQ, 32'h80);
    rd(`SMP_OFF_SYS_IRQ, 32'hF);
    bus(1'b0, `SMP_OFF_SYS_IRQ, 32'hE);
    watch(2, 1'b1);
    rd(`SMP_OFF_SYS_IRQ, 32'hE);
    chk({31'h0, cpu_irq}, 32'h0);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h1);
    bus(1'b0, `SMP_OFF_TB_IRQ, 32'h11);
    rd(`SMP_OFF_SYS_IRQ, 32'hF);
    watch(2, 1'b1);
    chk({31'h0, cpu_irq}, 32'h1);
    rd(`SMP_OFF_TB_IRQ, 32'h1F);
    $display("test interrupts done");
    bus(1'b0, `SMP_OFF_PERIOD, 32'h28);
    bus(1'b0, `SMP_OFF_FALL, 32'h1E);
    bus(1'b0, `SMP_OFF_MAIN_CTRL, 32'h3);
    watch(20, 1'b1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, `SMP_OFF_EVENT_SRC, 32'h100010 | (32'h100 << i) | (32'h1000000 << i));
      wait_ev(1'b0);
      pulse(smp_src_t'(4'h1 << i));
      watch(20, 1'b1);
      chk(n_re, 1);
      chk({31'h0, n_sd >= 3 && n_sd <= 5}, 32'h1);
    end
    bus(1'b0, `SMP_OFF_BLANK_CTRL, 32'h10);
    bus(1'b0, `SMP_OFF_FBLANK_TIME, 32'h14);
    bus(1'b0, `SMP_OFF_FBLANK_SRC, 32'h2);
    for (int m = 1; m >= 0; m--) begin
      bus(1'b0, `SMP_OFF_BLANK_CTRL, {26'h0, m[1:0], 4'h0});
      wait_ev(1'b1);
      wait_ev(1'b0);
      pulse(smp_src_t'(4'h2));
      watch(4, 1'b1);
      pulse(smp_src_t'(4'h2));
      watch(12, 1'b0);
      chk(n_re, (m == 1) ? 0 : 1);
    end
    $display("test async done");
    conclude();
  end
endmodule
